// ### inc/pin_cfg_regs.svh
// Register offsets, field positions, reset values for the pin and input config slice
// Assumes an 8-bit register address and 8-bit data on the host port
`ifndef PIN_CFG_REGS_SVH
`define PIN_CFG_REGS_SVH

`define OFF_PIN_ATT_CFG      8'h7D
`define OFF_FACTORY_TEST_A   8'h7E
`define OFF_FACTORY_TEST_B   8'h7F
`define OFF_LOCK_CFG         8'h40
`define OFF_DRIVE_CFG        8'h7C

`define RST_PIN_ATT_CFG      8'h00
`define RST_FACTORY_TEST     8'h00
`define RST_LOCK_BIT         1'b0
`define RST_DRIVE_FREQ       1'b0

`define FLD_ROLE_LSB         0
`define FLD_THR_LSB          2
`define FLD_BYPASS_LSB       4
`define FLD_LOCK_BIT         1
`define FLD_DRIVE_FREQ_BIT   1

`endif

// ### inc/pin_cfg_pkg.sv
// Types shared by the pin and input config slice
// Assumes nothing beyond a SystemVerilog compiler
package pin_cfg_pkg;

  typedef enum logic [1:0] {
    ROLE_FAN4_SPEED   = 2'b00,
    ROLE_OVERTEMP     = 2'b01,
    ROLE_ALERT_OUT    = 2'b10,
    ROLE_GPIO         = 2'b11
  } pin_role_t;

  typedef enum logic [1:0] {
    THR_20MV  = 2'b00,
    THR_40MV  = 2'b01,
    THR_80MV  = 2'b10,
    THR_130MV = 2'b11
  } tach_thr_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic      bypass_12v_divider;
    logic      bypass_5v_divider;
    logic      bypass_core_supply_divider;
    logic      bypass_2v5_divider;
    tach_thr_t two_wire_tach_threshold;
    pin_role_t shared_pin_role_select;
  } pin_att_cfg_t;

endpackage

// ### logic/pin_cfg_regs.sv
// Pin role, tach threshold and attenuator bypass register slice
// Assumes a host port master on sys_clk_in; read data one cycle after rd
`timescale 1ns/1ps
`include "pin_cfg_regs.svh"

module pin_cfg_regs (
  input  wire logic                    sys_clk_in,
  input  wire logic                    arst_n_in,
  input  wire pin_cfg_pkg::reg_req_t   req_in,
  output logic [7:0]                   rdata_out,
  output pin_cfg_pkg::pin_role_t       pin_role_out,
  output logic                         tach_thr_valid_out,
  output pin_cfg_pkg::tach_thr_t       tach_thr_out,
  output logic [3:0]                   bypass_out,
  output logic                         low_freq_drive_out,
  output logic                         cfg_locked_out
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  pin_cfg_pkg::pin_att_cfg_t cfg_q;
  pin_cfg_pkg::pin_att_cfg_t cfg_d;
  logic                      lock_q;
  logic                      lock_d;
  logic                      lf_q;
  logic                      lf_d;
  pin_cfg_pkg::tach_thr_t    thr_q;
  pin_cfg_pkg::tach_thr_t    thr_d;
  logic [7:0]                rdata_q;
  logic [7:0]                rdata_d;
  logic [7:0]                cfg_bits;
  logic                      hit_cfg;
  logic                      hit_lock;
  logic                      hit_drive;
  logic                      hit_test_a;
  logic                      hit_test_b;
  logic                      wr_cfg;
  logic                      wr_lock;
  logic                      wr_drive;

  // Factory hooks are not modelled; both test registers read as tied off
  localparam logic [7:0] FACTORY_TEST_VAL = `RST_FACTORY_TEST;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Full 8-bit compare, so no register aliases elsewhere in the map
  always_comb begin
    hit_cfg    = 1'b0;
    hit_lock   = 1'b0;
    hit_drive  = 1'b0;
    hit_test_a = 1'b0;
    hit_test_b = 1'b0;
    case (req_in.addr)
      `OFF_PIN_ATT_CFG: begin
        hit_cfg = 1'b1;
      end
      `OFF_LOCK_CFG: begin
        hit_lock = 1'b1;
      end
      `OFF_DRIVE_CFG: begin
        hit_drive = 1'b1;
      end
      `OFF_FACTORY_TEST_A: begin
        hit_test_a = 1'b1;
      end
      `OFF_FACTORY_TEST_B: begin
        hit_test_b = 1'b1;
      end
      default: begin
        // Unmapped addresses read zero and drop writes
      end
    endcase
  end

  // Test register writes match no enable and are dropped
  always_comb begin
    wr_cfg   = 1'b0;
    wr_lock  = 1'b0;
    wr_drive = 1'b0;
    if (req_in.wr) begin
      wr_lock = hit_lock;
      // Locked registers drop the write; the host sees no error
      if (!lock_q) begin
        wr_cfg   = hit_cfg;
        wr_drive = hit_drive;
      end
    end
  end

  // ****************************************************************
  // Lock, sticky until power-on reset
  // ****************************************************************
  always_comb begin
    lock_d = lock_q;
    if (wr_lock) begin
      // Writing zero never unlocks, so locked settings cannot be undone
      lock_d = lock_q | req_in.wdata[`FLD_LOCK_BIT];
    end
  end

  // Power-on only; no software path clears the lock
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lock_q <= `RST_LOCK_BIT;
    end else begin
      lock_q <= lock_d;
    end
  end

  // ****************************************************************
  // Pin role, threshold and bypass config
  // ****************************************************************
  always_comb begin
    cfg_d = cfg_q;
    // Whole byte lands at once; no field is write-protected alone
    if (wr_cfg) begin
      cfg_d = pin_cfg_pkg::pin_att_cfg_t'(req_in.wdata);
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_q <= pin_cfg_pkg::pin_att_cfg_t'(`RST_PIN_ATT_CFG);
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg_bits = cfg_q;

  // ****************************************************************
  // Drive frequency and effective tach threshold
  // ****************************************************************
  always_comb begin
    lf_d  = lf_q;
    thr_d = pin_cfg_pkg::THR_20MV;
    if (wr_drive) begin
      lf_d = req_in.wdata[`FLD_DRIVE_FREQ_BIT];
    end
    // Lowest code in high frequency keeps the comparator neutral
    if (lf_d) begin
      thr_d = cfg_d.two_wire_tach_threshold;
    end
  end

  // Registered from next values so the threshold never lags the mode bit
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lf_q  <= `RST_DRIVE_FREQ;
      thr_q <= pin_cfg_pkg::THR_20MV;
    end else begin
      lf_q  <= lf_d;
      thr_q <= thr_d;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_comb begin
    rdata_d = 8'h00;
    if (req_in.rd) begin
      if (hit_cfg) begin
        // Raw threshold code reads back whatever the drive mode
        rdata_d = cfg_bits;
      end
      if (hit_test_a) begin
        rdata_d = FACTORY_TEST_VAL;
      end
      if (hit_test_b) begin
        rdata_d = FACTORY_TEST_VAL;
      end
      if (hit_lock) begin
        rdata_d[`FLD_LOCK_BIT] = lock_q;
      end
      if (hit_drive) begin
        rdata_d[`FLD_DRIVE_FREQ_BIT] = lf_q;
      end
    end
  end

  // Registered so read data stand for exactly one cycle
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Outputs to pin mux, tach comparator and voltage front end
  // ****************************************************************
  assign rdata_out          = rdata_q;
  assign pin_role_out       = cfg_q.shared_pin_role_select;
  assign tach_thr_valid_out = lf_q;
  assign tach_thr_out       = thr_q;
  assign low_freq_drive_out = lf_q;
  assign cfg_locked_out     = lock_q;

  // One enable per measured channel, ordered 2v5, core, 5v, 12v
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_bypass
      assign bypass_out[g] = cfg_bits[`FLD_BYPASS_LSB + g];
    end
  endgenerate

endmodule

// ### sim/pin_cfg_chk.sv
// Assertions for the pin and input config slice
// Bound to pin_cfg_regs; sees its ports only
`timescale 1ns/1ps
module pin_cfg_chk (
  input wire logic                   sys_clk_in,
  input wire logic                   arst_n_in,
  input wire pin_cfg_pkg::reg_req_t  req_in,
  input wire logic [7:0]             rdata_out,
  input wire pin_cfg_pkg::pin_role_t pin_role_out,
  input wire pin_cfg_pkg::tach_thr_t tach_thr_out,
  input wire logic [3:0]             bypass_out,
  input wire logic                   low_freq_drive_out,
  input wire logic                   cfg_locked_out
);
  // ****
  // Checks
  // ****
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence wr_s;
    !cfg_locked_out && req_in.wr && req_in.addr == 8'h7D;
  endsequence
  lock_hold_a: assert property (cfg_locked_out |=>
    $stable({pin_role_out, bypass_out, tach_thr_out, low_freq_drive_out})) else $error("locked");
  lock_sticky_a: assert property (cfg_locked_out |=> cfg_locked_out)
    else $error("lock dropped");
  role_wr_a: assert property (wr_s |=> pin_role_out == $past(req_in.wdata[1:0]))
    else $error("role");
  thr_wr_a: assert property (wr_s ##0 low_freq_drive_out
    |=> tach_thr_out == $past(req_in.wdata[3:2])) else $error("thr");
  thr_hf_a: assert property (!low_freq_drive_out |-> tach_thr_out == 2'h0)
    else $error("thr hf");
  bypass_wr_a: assert property (wr_s |=> bypass_out == $past(req_in.wdata[7:4]))
    else $error("bypass");
  rst_zero_a: assert property ($rose(arst_n_in) |-> {pin_role_out, bypass_out} == 6'h00)
    else $error("reset");
  test_ro_a: assert property (req_in.rd && req_in.addr[7:1] == 7'h3F |=> rdata_out == 8'h00)
    else $error("test");
  freq_wr_a: assert property (!cfg_locked_out && req_in.wr && req_in.addr == 8'h7C
    |=> low_freq_drive_out == $past(req_in.wdata[1])) else $error("freq");
endmodule
bind pin_cfg_regs pin_cfg_chk chk_u (
  .sys_clk_in         (sys_clk_in),
  .arst_n_in          (arst_n_in),
  .req_in             (req_in),
  .rdata_out          (rdata_out),
  .pin_role_out       (pin_role_out),
  .tach_thr_out       (tach_thr_out),
  .bypass_out         (bypass_out),
  .low_freq_drive_out (low_freq_drive_out),
  .cfg_locked_out     (cfg_locked_out)
);

// ### sim/tb.sv
// Bench for the pin and input config slice
// Drives the host port directly; checker is bound
`timescale 1ns/1ps
module tb;
  logic sys_clk_in = 0, arst_n_in = 0, tach_thr_valid_out, low_freq_drive_out, cfg_locked_out;
  pin_cfg_pkg::reg_req_t req_in = '0;
  pin_cfg_pkg::pin_role_t pin_role_out;
  pin_cfg_pkg::tach_thr_t tach_thr_out;
  logic [7:0] rdata_out, v;
  logic [3:0] bypass_out;
  int err_total = 0, n_checks = 0;
  pin_cfg_regs dut_u (
    .sys_clk_in         (sys_clk_in),
    .arst_n_in          (arst_n_in),
    .req_in             (req_in),
    .rdata_out          (rdata_out),
    .pin_role_out       (pin_role_out),
    .tach_thr_valid_out (tach_thr_valid_out),
    .tach_thr_out       (tach_thr_out),
    .bypass_out         (bypass_out),
    .low_freq_drive_out (low_freq_drive_out),
    .cfg_locked_out     (cfg_locked_out)
  );
  // ****
  // Tasks
  // ****
  always #4 sys_clk_in = ~sys_clk_in;
  initial #20000 begin // Whole run is near 269 ns
    err_total++;
    give_verdict();
  end
  task automatic chk(logic [11:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  // Read passes the expected byte in d
  task automatic bus(logic [7:0] a, d, logic r);
    @(posedge sys_clk_in) req_in <= {a, r ? 8'h00 : d, !r, r};
    @(posedge sys_clk_in) req_in <= '0;
    #1 if (r) chk(rdata_out, d);
  endtask
  task automatic t_reset();
    chk({pin_role_out, tach_thr_out, bypass_out, low_freq_drive_out, cfg_locked_out}, '0);
    bus(8'h7D, 8'h00, 1'b1);
  endtask
  task automatic t_fields();
    bus(8'h7C, 8'h02, 1'b0);
    chk(low_freq_drive_out, 1'b1);
    for (int i = 0; i < 4; i++) begin
      v = {4'h1 << i, 2'(i), 2'(3 - i)};
      bus(8'h7D, v, 1'b0);
      chk({pin_role_out, tach_thr_out, bypass_out}, {v[1:0], v[3:2], v[7:4]});
    end
    bus(8'h7C, 8'h00, 1'b0);
    chk({low_freq_drive_out, tach_thr_valid_out, tach_thr_out}, '0);
    bus(8'h7D, 8'h8C, 1'b1);
  endtask
  task automatic t_lock();
    // Test registers are only ever read from the host side
    bus(8'h7E, 8'h00, 1'b1);
    bus(8'h7F, 8'h00, 1'b1);
    bus(8'h40, 8'h02, 1'b0);
    bus(8'h7D, 8'h55, 1'b0);
    bus(8'h7C, 8'h02, 1'b0);
    chk({cfg_locked_out, low_freq_drive_out, bypass_out}, 6'h28);
    bus(8'h7D, 8'h8C, 1'b1);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    #1 t_reset();
    t_fields();
    t_lock();
    @(posedge sys_clk_in) arst_n_in <= 1'b0;
    @(posedge sys_clk_in) arst_n_in <= 1'b1;
    #1 t_reset();
    give_verdict();
  end
endmodule
